//--- sls_pkg.sv
// ==========================================================
// Shared constants for the servo loop scheduler
package sls_pkg;
	// ==========================================================
	// Geometry
	localparam int AXES = 4; // Axis channels
	localparam int POS_W = 30; // Signed position width
	localparam int AOUT_W = 13; // Analog output width
	localparam int STRB_N = 8; // Two strobes per axis
	localparam int PROGS = 10; // Motion programs
	localparam int SUBRS = 40; // Subroutines
	localparam int STORE_N = PROGS + SUBRS; // Program store words

	// ==========================================================
	// Timing, in printed units, and derived cycle counts
	localparam int CLK_PS = 10000; // 100 MHz period
	localparam int CUR_LOOP_PS = 250000000; // Current loop 250 us
	localparam int TICK_CYC = CUR_LOOP_PS / CLK_PS; // Base tick in cycles
	localparam int CUR_LOOP_US = 250;
	localparam int VEL_LOOP_US = 1000; // Velocity loop 1 ms
	localparam int POS_LOOP_US = 2000; // Digital position loop 2 ms
	localparam int ANA_SLOT_US = 500; // Analog slot 0.5 ms
	localparam int VEL_AVG_US = 128000; // Actual velocity window 128 ms
	localparam int CMD_MAX_US = 4000; // Command latency bound 4 ms
	localparam logic [2:0] VEL_TICKS = 3'(VEL_LOOP_US / CUR_LOOP_US - 1);
	localparam logic [2:0] DIG_SLOT_TICKS = 3'(POS_LOOP_US / CUR_LOOP_US / 2 - 1);
	localparam logic [2:0] ANA_SLOT_TICKS = 3'(ANA_SLOT_US / CUR_LOOP_US - 1);
	localparam logic [9:0] AVG_TICKS = 10'(VEL_AVG_US / CUR_LOOP_US - 1);
	localparam int CNT_W = 25; // Base tick counter width

	// ==========================================================
	// Value ranges accepted from the host
	localparam logic signed [31:0] POS_MIN = -32'sd536870912;
	localparam logic signed [31:0] POS_MAX = 32'sd536870911;
	localparam logic [31:0] VEL_MAX = 32'h007F_FFFF; // 8,388,607
	localparam logic [31:0] ACC_MAX = 32'h3FFF_FFFF; // 1,073,741,823
	localparam logic [3:0] PARAM_VEL = 4'h0; // Parameter index holding velocity
	localparam logic [3:0] PARAM_ACC = 4'h1; // Parameter index holding accel

	// ==========================================================
	// Register word offsets (byte addresses)
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CMD_BITS = 8'h04;
	localparam logic [7:0] OFS_CMD_SEL = 8'h08;
	localparam logic [7:0] OFS_CMD_DATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ANALOG = 8'h14;
	localparam logic [7:0] OFS_PROG_IDX = 8'h18;
	localparam logic [7:0] OFS_PROG_DATA = 8'h1C;
	localparam logic [7:0] OFS_ACT_POS = 8'h20; // Four words
	localparam logic [7:0] OFS_ACT_VEL = 8'h30; // Four words
	localparam logic [7:0] OFS_STRB_POS = 8'h40; // Eight words
	localparam logic [7:0] OFS_FACEPLATE = 8'h60;
	localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

	// ==========================================================
	// Command word operations
	typedef enum logic [0:0]
	{
		OP_SET_POS = 1'b0,
		OP_LOAD_PARAM = 1'b1
	} sls_op_e;
endpackage

//--- sls_sched_if.sv
`timescale 1ns/10ps
// ==========================================================
// Scheduler to core carrier
interface sls_sched_if;
	logic digital; // Digital servo mode
	logic ll_en; // Local logic enabled
	logic [1:0] axis_cnt; // Configured axes minus one
	logic base_tick; // Every 250 us
	logic cur_tick; // Current loop update
	logic vel_tick; // Velocity loop update
	logic frame_tick; // Start of position loop interval
	logic [3:0] axis_tick; // Axis position loop slot
	logic ll_tick; // Local logic slot
	modport sched (input digital, ll_en, axis_cnt,
		output base_tick, cur_tick, vel_tick, frame_tick, axis_tick, ll_tick);
	modport core (output digital, ll_en, axis_cnt,
		input base_tick, cur_tick, vel_tick, frame_tick, axis_tick, ll_tick);
endinterface

//--- sls_sched.sv
`timescale 1ns/10ps
// ==========================================================
// Round-robin loop slot sequencer
module sls_sched #(
	parameter int TICK_CYC = sls_pkg::TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	sls_sched_if.sched s
);
	logic [sls_pkg::CNT_W-1:0] cyc_q; // Cycles within base tick
	logic [2:0] sub_q; // Ticks within slot
	logic [1:0] slot_q; // Current slot
	logic [2:0] nslot; // Slots per interval
	logic [2:0] slot_last; // Last tick index of a slot
	logic [2:0] served; // Axes that own a slot
	logic [2:0] ll_slot; // Slot handed to local logic
	logic tick; // Base tick strobe
	logic slot_end; // Slot boundary
	logic [1:0] next_slot; // Slot about to begin
	logic [2:0] need; // Analog slots requested

	// ==========================================================
	// Slot plan decode
	assign tick = (cyc_q == sls_pkg::CNT_W'(TICK_CYC - 1));
	assign need = 3'({1'b0, s.axis_cnt}) + 3'd1 + 3'({2'b00, s.ll_en});
	assign nslot = s.digital ? 3'd2 : (need == 3'd1 ? 3'd1 : (need == 3'd2 ? 3'd2 : 3'd4));
	assign slot_last = s.digital ? sls_pkg::DIG_SLOT_TICKS : sls_pkg::ANA_SLOT_TICKS;
	assign ll_slot = (s.ll_en && !s.digital) ? nslot - 3'd1 : 3'd7;
	assign served = s.digital ? ((s.axis_cnt == 2'd0) ? 3'd1 : 3'd2) : 3'({1'b0, s.axis_cnt}) + 3'd1;
	assign slot_end = tick && (sub_q == slot_last);
	assign next_slot = (3'({1'b0, slot_q}) == nslot - 3'd1) ? 2'd0 : slot_q + 2'd1;

	// ==========================================================
	// Counters; a config change takes hold at once, even mid-slot
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cyc_q <= '0;
			sub_q <= '0;
			slot_q <= '0;
		end
		else
		begin
			cyc_q <= tick ? '0 : cyc_q + 1'b1;
			if (slot_end)
			begin
				sub_q <= '0;
				slot_q <= next_slot;
			end
			else if (tick)
				sub_q <= sub_q + 3'd1;
		end
	end

	// ==========================================================
	// Registered event strobes, one cycle each
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s.base_tick <= 1'b0;
			s.cur_tick <= 1'b0;
			s.vel_tick <= 1'b0;
			s.frame_tick <= 1'b0;
			s.axis_tick <= '0;
			s.ll_tick <= 1'b0;
		end
		else
		begin
			s.base_tick <= tick;
			s.cur_tick <= tick && s.digital;
			s.vel_tick <= tick && s.digital && (sub_q[1:0] == sls_pkg::VEL_TICKS[1:0]);
			s.frame_tick <= slot_end && (next_slot == 2'd0);
			s.ll_tick <= slot_end && (3'({1'b0, next_slot}) == ll_slot);
			for (int a = 0; a < sls_pkg::AXES; a++)
				s.axis_tick[a] <= slot_end && (next_slot == 2'(a)) && (3'(a) < served)
					&& (3'(a) != ll_slot);
		end
	end
endmodule

//--- sls_core.sv
`timescale 1ns/10ps
// How it works
// - Digital loops at 250us, 1ms, 2ms
// - Analog interval 0.5, 1, 2 ms by axes
// - Local logic takes the last analog slot (second with one axis, else fourth)
// - Status refreshed once per position interval
// - Actual velocity averaged, refreshed every 128ms
// - Host commands acted on within 4ms
// - Faceplate branch within one position interval
// - Local logic sees data at loop rate
// - Command bits start, abort, clear; words load
// - Position, velocity, acceleration ranges enforced
// - Two capture strobes per axis
// - 13-bit analog out, host or monitor
// - Axes one and two start together
// - Store for 10 programs, 40 subroutines
// - Strobe edge captured, published within interval
module sls_core #(
	parameter int TICK_CYC = sls_pkg::TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [sls_pkg::AXES*sls_pkg::POS_W-1:0] axis_pos_in,
	input wire logic [sls_pkg::STRB_N-1:0] strobe_in,
	input wire logic [3:0] faceplate_control_input,
	input wire logic [sls_pkg::AOUT_W-1:0] tune_mon_in,
	output logic [3:0] axis_start,
	output logic [3:0] axis_abort,
	output logic [3:0] pos_load,
	output logic [sls_pkg::POS_W-1:0] pos_load_val,
	output logic param_load,
	output logic [3:0] param_idx,
	output logic [31:0] param_val,
	output logic [1:0] param_axis,
	output logic [sls_pkg::AOUT_W-1:0] analog_out,
	output logic [3:0] prog_branch,
	output logic current_loop,
	output logic velocity_loop,
	output logic [3:0] position_loop,
	output logic local_logic_run
);
	localparam int AX = sls_pkg::AXES;
	localparam int PW = sls_pkg::POS_W;

	// ==========================================================
	// Helpers
	// Scale a 128 ms position delta to units per second (x1000/128)
	function automatic logic [31:0] vel_scale(input logic [PW-1:0] delta);
		logic signed [41:0] p;
		p = 42'(signed'(delta)) * 42'sd125;
		return 32'(p >>> 4);
	endfunction
	// Pick one axis position out of the flat bus
	function automatic logic [PW-1:0] pos_of(input logic [AX*PW-1:0] bus, input int a);
		return bus[a*PW +: PW];
	endfunction

	// ==========================================================
	// State
	sls_sched_if sif();
	logic [31:0] config_q; // [0] digital [1] local logic [3:2] axes-1 [4] monitor
	logic [3:0] pend_start_q; // Start requests waiting for the interval
	logic [3:0] pend_abort_q; // Abort requests waiting for the interval
	logic pend_sync_q; // Synchronised start of axes one and two
	logic [31:0] cmd_sel_q; // [1:0] axis [2] op [7:4] param index
	logic [31:0] cmd_data_q; // Command word value
	logic cmd_pend_q; // Command word waiting
	logic range_err_q; // Last command word out of range
	logic [sls_pkg::STRB_N-1:0] strb_prev_q; // Strobe history for edges
	logic [sls_pkg::STRB_N-1:0] strb_flag_q; // Sticky capture flags
	logic [PW-1:0] strb_hold_q [sls_pkg::STRB_N]; // Raw captures
	logic [PW-1:0] strb_pos_q [sls_pkg::STRB_N]; // Published captures
	logic [PW-1:0] act_pos_q [AX]; // Published positions
	logic [PW-1:0] avg_base_q [AX]; // Positions at window start
	logic [31:0] act_vel_q [AX]; // Published velocities
	logic [9:0] avg_cnt_q; // Ticks into velocity window
	logic [sls_pkg::AOUT_W-1:0] host_aout_q; // Host analog value
	logic [5:0] prog_idx_q; // Program store pointer
	logic [31:0] store_q [sls_pkg::STORE_N]; // Program store
	logic [3:0] ctl_seen_q; // Faceplate inputs at last interval

	// ==========================================================
	// Bus decode
	logic setup;
	logic wr;
	logic [5:0] widx;
	logic idx_ok;
	logic hit;
	logic [31:0] rd_mux;
	logic [sls_pkg::STRB_N-1:0] strb_edge;
	logic [sls_pkg::STRB_N-1:0] strb_clr;
	logic signed [31:0] cmd_sval;
	logic cmd_ok;
	logic [31:0] status;

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && pready; // Write lands at the access edge
	assign widx = paddr[7:2];
	assign idx_ok = (prog_idx_q < 6'(sls_pkg::STORE_N));
	assign hit = (paddr[1:0] == 2'b00) && (paddr <= sls_pkg::OFS_FACEPLATE)
		&& (paddr < sls_pkg::OFS_STRB_POS + 8'h20 || paddr == sls_pkg::OFS_FACEPLATE)
		&& (paddr != sls_pkg::OFS_PROG_DATA || idx_ok);
	assign strb_edge = strobe_in & ~strb_prev_q;
	assign strb_clr = (wr && paddr == sls_pkg::OFS_CMD_BITS) ? pwdata[15:8] : '0;
	assign cmd_sval = signed'(cmd_data_q);
	// Values outside the documented ranges are refused, not clipped
	assign cmd_ok = (cmd_sel_q[2] == sls_pkg::OP_SET_POS)
		? (cmd_sval >= sls_pkg::POS_MIN && cmd_sval <= sls_pkg::POS_MAX)
		: (cmd_sel_q[7:4] == sls_pkg::PARAM_VEL)
			? (cmd_data_q >= 32'h0000_0001 && cmd_data_q <= sls_pkg::VEL_MAX)
			: (cmd_sel_q[7:4] == sls_pkg::PARAM_ACC)
				? (cmd_data_q >= 32'h0000_0001 && cmd_data_q <= sls_pkg::ACC_MAX) : 1'b1;
	assign status = {18'h0, range_err_q, cmd_pend_q, strb_flag_q, pend_start_q};
	assign rd_mux = !hit ? 32'h0000_0000
		: paddr == sls_pkg::OFS_CONFIG ? config_q
		: paddr == sls_pkg::OFS_CMD_BITS ? {15'h0, pend_sync_q, 8'h0, pend_abort_q, pend_start_q}
		: paddr == sls_pkg::OFS_CMD_SEL ? cmd_sel_q
		: paddr == sls_pkg::OFS_CMD_DATA ? cmd_data_q
		: paddr == sls_pkg::OFS_STATUS ? status
		: paddr == sls_pkg::OFS_ANALOG ? 32'(analog_out)
		: paddr == sls_pkg::OFS_PROG_IDX ? 32'(prog_idx_q)
		: paddr == sls_pkg::OFS_PROG_DATA ? store_q[prog_idx_q]
		: paddr == sls_pkg::OFS_FACEPLATE ? 32'(ctl_seen_q)
		: paddr < sls_pkg::OFS_ACT_VEL ? 32'(signed'(act_pos_q[widx[1:0]]))
		: paddr < sls_pkg::OFS_STRB_POS ? act_vel_q[widx[1:0]]
		: 32'(signed'(strb_pos_q[widx[2:0]]));
	assign sif.digital = config_q[0];
	assign sif.ll_en = config_q[1];
	assign sif.axis_cnt = config_q[3:2];

	// ==========================================================
	// Loop sequencer
	sls_sched #(
		.TICK_CYC(TICK_CYC)
	) u_sched (
		.pclk(pclk),
		.presetn(presetn),
		.s(sif.sched)
	);

	// ==========================================================
	// APB answer: one wait-free access, data set up in setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !hit;
			prdata <= setup ? rd_mux : prdata;
		end
	end

	// ==========================================================
	// Host-written configuration and data registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			config_q <= sls_pkg::CONFIG_RST;
			cmd_sel_q <= '0;
			host_aout_q <= '0;
			prog_idx_q <= '0;
		end
		else if (wr && hit)
		begin
			// Unmapped writes are dropped and flagged through pslverr
			if (paddr == sls_pkg::OFS_CONFIG)
				config_q <= {27'h0, pwdata[4:0]};
			if (paddr == sls_pkg::OFS_CMD_SEL)
				cmd_sel_q <= {24'h0, pwdata[7:4], 1'b0, pwdata[2:0]};
			if (paddr == sls_pkg::OFS_ANALOG)
				host_aout_q <= pwdata[sls_pkg::AOUT_W-1:0];
			if (paddr == sls_pkg::OFS_PROG_IDX)
				prog_idx_q <= pwdata[5:0];
		end
	end

	// ==========================================================
	// Program store; no reset so it maps onto memory
	always_ff @(posedge pclk)
	begin
		if (wr && hit && paddr == sls_pkg::OFS_PROG_DATA)
			store_q[prog_idx_q] <= pwdata;
	end

	// ==========================================================
	// Command bits and words; all but the strobe flag clears run at the next interval
	// start, at most 2 ms away, which keeps well inside 4 ms
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_start_q <= '0;
			pend_abort_q <= '0;
			pend_sync_q <= 1'b0;
			cmd_data_q <= '0;
			cmd_pend_q <= 1'b0;
			range_err_q <= 1'b0;
			axis_start <= '0;
			axis_abort <= '0;
			pos_load <= '0;
			pos_load_val <= '0;
			param_load <= 1'b0;
			param_idx <= '0;
			param_val <= '0;
			param_axis <= '0;
		end
		else
		begin
			axis_start <= '0;
			axis_abort <= '0;
			pos_load <= '0;
			param_load <= 1'b0;
			if (sif.frame_tick)
			begin
				axis_abort <= pend_abort_q;
				// Abort wins over a start raised in the same interval
				axis_start <= (pend_start_q | {2'b00, {2{pend_sync_q}}}) & ~pend_abort_q;
				pend_start_q <= '0;
				pend_abort_q <= '0;
				pend_sync_q <= 1'b0;
				if (cmd_pend_q)
				begin
					cmd_pend_q <= 1'b0;
					range_err_q <= !cmd_ok;
					if (cmd_ok && cmd_sel_q[2] == sls_pkg::OP_SET_POS)
					begin
						pos_load[cmd_sel_q[1:0]] <= 1'b1;
						pos_load_val <= cmd_data_q[PW-1:0];
					end
					else if (cmd_ok)
					begin
						param_load <= 1'b1;
						param_idx <= cmd_sel_q[7:4];
						param_val <= cmd_data_q;
						param_axis <= cmd_sel_q[1:0];
					end
				end
			end
			// Requests arriving now join the following interval
			if (wr && paddr == sls_pkg::OFS_CMD_BITS)
			begin
				pend_start_q <= (sif.frame_tick ? 4'h0 : pend_start_q) | pwdata[3:0];
				pend_abort_q <= (sif.frame_tick ? 4'h0 : pend_abort_q) | pwdata[7:4];
				pend_sync_q <= (sif.frame_tick ? 1'b0 : pend_sync_q) | pwdata[16];
			end
			if (wr && paddr == sls_pkg::OFS_CMD_DATA)
			begin
				cmd_data_q <= pwdata;
				cmd_pend_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Strobe capture and sticky flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strb_prev_q <= '0;
			strb_flag_q <= '0;
			for (int k = 0; k < sls_pkg::STRB_N; k++)
			begin
				strb_hold_q[k] <= '0;
				strb_pos_q[k] <= '0;
			end
		end
		else
		begin
			strb_prev_q <= strobe_in;
			strb_flag_q <= (strb_flag_q & ~strb_clr) | strb_edge;
			for (int k = 0; k < sls_pkg::STRB_N; k++)
			begin
				if (strb_edge[k])
					strb_hold_q[k] <= pos_of(axis_pos_in, k / 2);
				if (sif.axis_tick[k / 2])
					strb_pos_q[k] <= strb_hold_q[k];
			end
		end
	end

	// ==========================================================
	// Position status and averaged velocity
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			avg_cnt_q <= '0;
			for (int a = 0; a < AX; a++)
			begin
				act_pos_q[a] <= '0;
				avg_base_q[a] <= '0;
				act_vel_q[a] <= '0;
			end
		end
		else
		begin
			if (sif.base_tick)
				avg_cnt_q <= (avg_cnt_q == sls_pkg::AVG_TICKS) ? 10'd0 : avg_cnt_q + 10'd1;
			for (int a = 0; a < AX; a++)
			begin
				if (sif.axis_tick[a])
					act_pos_q[a] <= pos_of(axis_pos_in, a);
				if (sif.base_tick && avg_cnt_q == sls_pkg::AVG_TICKS)
				begin
					// Mean over the window; too slow for fast control
					act_vel_q[a] <= vel_scale(pos_of(axis_pos_in, a) - avg_base_q[a]);
					avg_base_q[a] <= pos_of(axis_pos_in, a);
				end
			end
		end
	end

	// ==========================================================
	// Loop strobes, faceplate branch and analog output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_seen_q <= '0;
			prog_branch <= '0;
			analog_out <= '0;
			current_loop <= 1'b0;
			velocity_loop <= 1'b0;
			position_loop <= '0;
			local_logic_run <= 1'b0;
		end
		else
		begin
			if (sif.frame_tick)
			begin
				ctl_seen_q <= faceplate_control_input;
				prog_branch <= faceplate_control_input;
			end
			analog_out <= config_q[4] ? tune_mon_in : host_aout_q;
			current_loop <= sif.cur_tick;
			velocity_loop <= sif.vel_tick;
			position_loop <= sif.axis_tick;
			local_logic_run <= sif.ll_tick;
		end
	end
endmodule

//--- sls_core_assertions.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the loop scheduler core
module sls_core_chk #(
	parameter int TICK_CYC = sls_pkg::TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] axis_start,
	input wire logic [3:0] axis_abort,
	input wire logic [3:0] pos_load,
	input wire logic [sls_pkg::POS_W-1:0] pos_load_val,
	input wire logic param_load,
	input wire logic [3:0] param_idx,
	input wire logic [31:0] param_val,
	input wire logic current_loop,
	input wire logic [3:0] position_loop,
	input wire logic local_logic_run
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Gap counters; the seen flags skip the first event
	logic [31:0] cgap_q, cgap_d, pgap_q, pgap_d;
	logic cseen_q, cseen_d, pseen_q, pseen_d;
	logic slot; // Any axis or local logic slot
	assign slot = |position_loop | local_logic_run;
	assign cgap_d = current_loop ? 32'h0 : cgap_q + 32'h1;
	// A mode change stops the tick, so a long gap forgets history
	assign cseen_d = current_loop | (cseen_q & (cgap_q < 32'(TICK_CYC)));
	assign pgap_d = slot ? 32'h0 : pgap_q + 32'h1;
	assign pseen_d = slot | pseen_q;
	// Counter registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cgap_q <= 32'h0;
			cseen_q <= 1'b0;
			pgap_q <= 32'h0;
			pseen_q <= 1'b0;
		end
		else
		begin
			cgap_q <= cgap_d;
			cseen_q <= cseen_d;
			pgap_q <= pgap_d;
			pseen_q <= pseen_d;
		end
	end
	// ==========================================================
	// Bus answer and schedule properties
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_apb_answer: assert property (s_setup |=> s_access ##1 !pready)
		else $error("bus answer not one access cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_cur_period: assert property (current_loop && cseen_q |-> cgap_q == TICK_CYC - 1)
		else $error("current loop period wrong");
	a_slot_spacing: assert property (slot && pseen_q |-> pgap_q >= 2 * TICK_CYC - 1)
		else $error("slot shorter than two ticks");
	a_one_slot_owner: assert property ($onehot0({local_logic_run, position_loop}))
		else $error("two slot owners at once");
	a_abort_wins: assert property ((axis_start & axis_abort) == 4'h0)
		else $error("start and abort together");
	a_load_val_hold: assert property (!$stable(pos_load_val) |-> pos_load != 4'h0)
		else $error("position value moved without load");
	a_param_hold: assert property (!$stable(param_val) |-> param_load)
		else $error("parameter value moved without load");
	a_vel_range: assert property (param_load && param_idx == sls_pkg::PARAM_VEL
		|-> param_val >= 32'h1 && param_val <= sls_pkg::VEL_MAX)
		else $error("velocity out of range loaded");
	a_acc_range: assert property (param_load && param_idx == sls_pkg::PARAM_ACC
		|-> param_val >= 32'h1 && param_val <= sls_pkg::ACC_MAX)
		else $error("acceleration out of range loaded");
endmodule
bind sls_core sls_core_chk #(.TICK_CYC(TICK_CYC)) i_sls_core_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.axis_start(axis_start), .axis_abort(axis_abort), .pos_load(pos_load),
	.pos_load_val(pos_load_val), .param_load(param_load), .param_idx(param_idx),
	.param_val(param_val), .current_loop(current_loop), .position_loop(position_loop),
	.local_logic_run(local_logic_run));

//--- sls_host.sv
`timescale 1ns/10ps
// ==========================================================
// Host controller model: one bus word per call
module sls_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic [31:0] rdat; // Last read word
	logic err; // Last error flag
	int late = 0; // Transfers that never got ready
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Commands go out as whole words at sweep end; status read any time
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			late++;
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data lines show junk, not the old word
		pwdata <= ~d;
	endtask
endmodule

//--- tb_servo_loop_scheduler.sv
`timescale 1ns/10ps
// ==========================================================
// Bench: host calls with expected values
module tb_servo_loop_scheduler;
	localparam int T = 20; // Short base tick
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, param_load, current_loop;
	logic velocity_loop, local_logic_run;
	logic [7:0] paddr;
	logic [7:0] strobe_in = 8'h00;
	logic [31:0] pwdata, prdata, param_val, v;
	logic [119:0] axis_pos_in = 120'h0;
	logic [3:0] fp = 4'h0;
	logic [12:0] tune = 13'h0;
	logic [3:0] axis_start, axis_abort, pos_load, param_idx, prog_branch, position_loop;
	logic [29:0] pos_load_val;
	logic [12:0] analog_out;
	logic [19:0] ev; // Pulse outputs by index
	int failures = 0;
	int n_checks = 0;
	int np, nl, k, s;
	// Command table: select, data, accepted
	logic [31:0] cs [8] = '{32'h1, 32'h2, 32'h1, 32'h4, 32'h4, 32'h14, 32'h14, 32'h4};
	logic [31:0] cd [8] = '{32'h1FFF_FFFF, 32'hE000_0000, 32'h2000_0000, sls_pkg::VEL_MAX,
		32'h0, sls_pkg::ACC_MAX, 32'h4000_0000, 32'h0080_0000};
	logic [7:0] ok_m = 8'h2B;
	assign ev = {param_load, pos_load, axis_abort, axis_start, local_logic_run,
		position_loop, velocity_loop, current_loop};
	always #5 pclk = ~pclk;
	sls_core #(.TICK_CYC(T)) i_sls_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .axis_pos_in(axis_pos_in), .strobe_in(strobe_in),
		.faceplate_control_input(fp), .tune_mon_in(tune), .axis_start(axis_start),
		.axis_abort(axis_abort), .pos_load(pos_load), .pos_load_val(pos_load_val),
		.param_load(param_load), .param_idx(param_idx), .param_val(param_val),
		.param_axis(), .analog_out(analog_out), .prog_branch(prog_branch),
		.current_loop(current_loop), .velocity_loop(velocity_loop),
		.position_loop(position_loop), .local_logic_run(local_logic_run));
	sls_host i_sls_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ==========================================================
	// Shared tasks
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task give_verdict;
		failures += i_sls_host.late;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_sls_host.xfer(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a);
		i_sls_host.xfer(1'b0, a, 32'h0);
		v = i_sls_host.rdat;
	endtask
	// Bounded wait for one pulse; a missing wanted pulse ends the run
	task wait_ev(input int i, input int lim, input logic e);
		int n;
		logic hit;
		n = 0;
		hit = 1'b0;
		while (!hit && n < lim)
		begin
			@(posedge pclk);
			n++;
			hit = (ev[i] === 1'b1);
		end
		chk(32'(hit), 32'(e));
		if (e && !hit)
			give_verdict();
	endtask
	// Period of pulse i, counting slot owners inside it
	task gap(input int i, input int e);
		int c;
		wait_ev(i, 2000, 1'b1);
		wait_ev(i, 2000, 1'b1);
		c = 0;
		np = 0;
		nl = 0;
		do
		begin
			@(posedge pclk);
			c++;
			if (|position_loop === 1'b1)
				np++;
			if (local_logic_run === 1'b1)
				nl++;
		end
		while (ev[i] !== 1'b1 && c < 2000);
		chk(c, e);
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(sls_pkg::OFS_CONFIG);
		chk(v, sls_pkg::CONFIG_RST);
		rd(8'h64);
		chk(32'(i_sls_host.err), 32'h1);
		chk(v, 32'h0);
		// Digital servo loops
		wr(sls_pkg::OFS_CONFIG, 32'h5);
		gap(0, T);
		gap(1, 4 * T);
		gap(2, 8 * T);
		chk(np, 2);
		// Analog intervals by axis count, with and without local logic
		for (int a = 1; a <= 4; a++)
			for (int ll = 0; ll < 2; ll++)
			begin
				wr(sls_pkg::OFS_CONFIG, {28'h0, 2'(a - 1), ll[0], 1'b0});
				s = (a + ll > 2) ? 4 : a + ll;
				gap(2, s * 2 * T);
				chk(np, (ll == 1 && a == 4) ? 3 : a);
				chk(nl, ll);
			end
		// Command words, boundary values on both sides
		for (int i = 0; i < 8; i++)
		begin
			wr(sls_pkg::OFS_CMD_SEL, cs[i]);
			wr(sls_pkg::OFS_CMD_DATA, cd[i]);
			k = cs[i][2] ? 19 : 15 + int'(cs[i][1:0]);
			wait_ev(k, 16 * T, ok_m[i]);
			if (ok_m[i])
				chk(cs[i][2] ? param_val : 32'(pos_load_val), cs[i][2] ? cd[i] : {2'b00, cd[i][29:0]});
			rd(sls_pkg::OFS_STATUS);
			chk(32'(v[13]), 32'(!ok_m[i]));
		end
		// Abort beats start; paired start
		wr(sls_pkg::OFS_CMD_BITS, 32'h11);
		wait_ev(11, 16 * T, 1'b1);
		chk(32'(axis_start[0]), 32'h0);
		wr(sls_pkg::OFS_CMD_BITS, 32'h0001_0000);
		wait_ev(8, 16 * T, 1'b1);
		chk(32'(axis_start[0]), 32'h1);
		// Strobe capture on axis 1, first strobe
		axis_pos_in[59:30] <= 30'h2000_0005;
		strobe_in <= 8'h04;
		@(posedge pclk);
		strobe_in <= 8'h00;
		wait_ev(3, 2000, 1'b1);
		rd(sls_pkg::OFS_STATUS);
		chk(32'(v[6]), 32'h1);
		rd(sls_pkg::OFS_STRB_POS + 8'h08);
		chk(v, 32'hE000_0005);
		// Faceplate, position status and flag clear
		fp <= 4'hA;
		axis_pos_in[29:0] <= 30'h0000_1234;
		wr(sls_pkg::OFS_CMD_BITS, 32'h400);
		wait_ev(2, 2000, 1'b1);
		wait_ev(2, 2000, 1'b1);
		chk(32'(prog_branch), 32'hA);
		rd(sls_pkg::OFS_FACEPLATE);
		chk(v, 32'hA);
		rd(sls_pkg::OFS_ACT_POS);
		chk(v, 32'h1234);
		rd(sls_pkg::OFS_STATUS);
		chk(32'(v[6]), 32'h0);
		// Analog output, host value then monitor
		wr(sls_pkg::OFS_ANALOG, 32'h1ABC);
		rd(sls_pkg::OFS_ANALOG);
		chk(v, 32'h1ABC);
		chk(32'(analog_out), 32'h1ABC);
		tune <= 13'h0F0F;
		wr(sls_pkg::OFS_CONFIG, 32'h11);
		wait_ev(2, 2000, 1'b1);
		wait_ev(2, 2000, 1'b1);
		chk(32'(analog_out), 32'h0F0F);
		// Program store, last word and one past
		wr(sls_pkg::OFS_PROG_IDX, 32'd49);
		wr(sls_pkg::OFS_PROG_DATA, 32'hA5A5_5A5A);
		rd(sls_pkg::OFS_PROG_DATA);
		chk(v, 32'hA5A5_5A5A);
		wr(sls_pkg::OFS_PROG_IDX, 32'd50);
		rd(sls_pkg::OFS_PROG_DATA);
		chk(32'(i_sls_host.err), 32'h1);
		give_verdict();
	end
endmodule
